// >>> rtl/smx_pkg.sv
// Package: constants, types and register map of the guest-switch handling block
// Operation
// - Three interrupt sources: internal, external sync, async
// - Flag low: drop internal, hold external pending
// - Intercepted internal: guest exit, not pending
// - Intercepted external: guest exit, stays pending
// - Unintercepted: taken inside guest, guest state saved
// - Resume returns to guest with handler edits
// - Setting flag after exit takes pending interrupt
// - Lock bit set keeps mode registers locked
// - Locked mode control register write raises fault
// - Entering mode remaps private memory
// - Record bit set records last four transfers
// - Entry saves five host, loads five guest
// - Exit saves five guest, reloads five host
// - Extended debug control swapped both directions
// - Stack registers: entry restores, exit saves only
// - Encrypted guest exit clears stack registers
// - Feature query reports swap support bit
package smx_pkg;
    localparam int SMX_AW = 6;
    localparam int SMX_NREC = 5;
    localparam logic [SMX_AW-1:0] SMX_CTRL_OFF = 6'h00;
    localparam logic [SMX_AW-1:0] SMX_STAT_OFF = 6'h04;
    localparam logic [SMX_AW-1:0] SMX_MCTL_OFF = 6'h08;
    localparam logic [SMX_AW-1:0] SMX_MBASE_OFF = 6'h0C;
    localparam logic [SMX_AW-1:0] SMX_EDBG_OFF = 6'h10;
    localparam logic [SMX_AW-1:0] SMX_STK_OFF = 6'h14;
    localparam logic [SMX_AW-1:0] SMX_REC_OFF = 6'h20;
    localparam int SMX_CTRL_GIF = 0;
    localparam int SMX_CTRL_INTC = 1;
    localparam int SMX_CTRL_LOCK = 2;
    localparam int SMX_CTRL_SWAP = 3;
    localparam int SMX_CTRL_ENC = 4;
    localparam int SMX_CTRL_GUEST = 5;
    localparam logic [31:0] SMX_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SMX_MBASE_RST = 32'h0003_0000;
    localparam int SMX_DBG_REC_BIT = 0;
    localparam logic [7:0] SMX_EXIT_SMI = 8'h62;
    localparam logic SMX_SWAP_SUPPORTED = 1'b1;

    typedef enum logic [1:0] {
        SMX_SRC_INT_SYNC,
        SMX_SRC_EXT_SYNC,
        SMX_SRC_EXT_ASYNC
    } smx_src_t;

    typedef struct packed {
        logic        valid;
        smx_src_t    src;
    } smx_irq_t;

    typedef struct packed {
        logic        exit_req;
        logic [7:0]  exit_code;
        logic        enter_mode;
        logic        fault;
    } smx_evt_t;
endpackage

// >>> rtl/smx_apb_slave.sv
// APB slave front end: decode and zero-wait handshake
`timescale 1ns/1ps
`default_nettype none
module smx_apb_slave
    import smx_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [SMX_AW-1:0] i_paddr,
    input  wire logic [31:0]       i_rdata_mux,
    output logic                   o_pready,
    output logic                   o_wr_stb,
    output logic                   o_rd_stb,
    output logic [31:0]            o_prdata
);
    // Zero-wait slave: access phase completes on its first cycle
    assign o_pready = 1'b1;
    assign o_wr_stb = i_psel & i_penable & i_pwrite;
    assign o_rd_stb = i_psel & i_penable & ~i_pwrite;
    assign o_prdata = i_rdata_mux;
endmodule
`default_nettype wire

// >>> rtl/smx_rec_bank.sv
// Bank of branch-record registers with save and load for world switch
`timescale 1ns/1ps
`default_nettype none
module smx_rec_bank
    import smx_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic        i_wr,
    input  wire logic [2:0]  i_widx,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_entry,
    input  wire logic        i_exit,
    input  wire logic [2:0]  i_ridx,
    output logic [31:0]      o_live,
    output logic [31:0]      o_guest,
    output logic [31:0]      o_host,
    output logic             o_rec_en
);
    logic [31:0] live_reg  [SMX_NREC];
    logic [31:0] guest_reg [SMX_NREC];
    logic [31:0] host_reg  [SMX_NREC];

    genvar g;
    generate
        for (g = 0; g < SMX_NREC; g++)
        begin : g_rec
            always_ff @(posedge i_core_clk)
            begin
                if (i_reset)
                begin
                    live_reg[g]  <= 32'h0000_0000;
                    guest_reg[g] <= 32'h0000_0000;
                    host_reg[g]  <= 32'h0000_0000;
                end
                else if (i_entry)
                begin
                    host_reg[g] <= live_reg[g];
                    live_reg[g] <= guest_reg[g];
                end
                else if (i_exit)
                begin
                    guest_reg[g] <= live_reg[g];
                    live_reg[g]  <= host_reg[g];
                end
                else if (i_wr && i_widx == 3'(g))
                    live_reg[g] <= i_wdata;
            end
        end
    endgenerate

    always_comb
    begin
        o_live  = 32'h0000_0000;
        o_guest = 32'h0000_0000;
        o_host  = 32'h0000_0000;
        if (i_ridx < 3'(SMX_NREC))
        begin
            o_live  = live_reg[i_ridx];
            o_guest = guest_reg[i_ridx];
            o_host  = host_reg[i_ridx];
        end
    end

    // Record enable from the live debug control word, not the read index
    assign o_rec_en = live_reg[0][SMX_DBG_REC_BIT];
endmodule
`default_nettype wire

// >>> rtl/smx_guest_switch.sv
// Management interrupt intercept and branch-record swap on guest switch
`timescale 1ns/1ps
`default_nettype none
module smx_guest_switch
    import smx_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_reset,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [SMX_AW-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic                   o_pready,
    output logic [31:0]            o_prdata,
    output logic                   o_pslverr,
    input  wire smx_irq_t          i_irq,
    input  wire logic              i_set_gif,
    input  wire logic              i_clr_gif,
    input  wire logic              i_guest_entry,
    input  wire logic              i_resume,
    input  wire logic              i_branch_taken,
    input  wire logic              i_debug_exc,
    input  wire logic [31:0]       i_branch_src,
    input  wire logic [31:0]       i_branch_dst,
    output smx_evt_t               o_evt,
    output logic                   o_in_mgmt_mode,
    output logic                   o_priv_mem_map,
    output logic                   o_swap_supported
);
    logic [31:0] ctrl_reg;
    logic [31:0] mctl_reg;
    logic [31:0] mbase_reg;
    logic [31:0] edbg_reg;
    logic [31:0] edbg_host_reg;
    logic [31:0] edbg_guest_reg;
    logic [31:0] stk_reg;
    logic [31:0] stk_guest_reg;
    logic        ext_pend_reg;
    logic        in_mode_reg;
    logic        mode_from_guest_reg;
    logic        fault_reg;
    logic        fault_seen_reg;
    logic        exit_reg;
    logic        enter_reg;
    logic [1:0]  rec_ptr_reg;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic [31:0] rec_live;
    logic        rec_en;
    logic [31:0] stat_word;
    logic        rec_wr;
    logic [2:0]  rec_widx;
    logic [31:0] rec_wdata;
    logic        do_entry;
    logic        do_exit;
    logic        global_interrupt_flag;
    logic        intc;
    logic        swap;
    logic        in_guest;
    logic        int_irq;
    logic        new_ext;
    logic        ext_irq;
    logic        take_int;
    logic        take_ext;
    logic        exit_now;
    logic        locked_wr;

    smx_apb_slave u_apb (
        .i_core_clk (i_core_clk),
        .i_psel     (i_psel),
        .i_penable  (i_penable),
        .i_pwrite   (i_pwrite),
        .i_paddr    (i_paddr),
        .i_rdata_mux(rdata),
        .o_pready   (o_pready),
        .o_wr_stb   (wr_stb),
        .o_rd_stb   (rd_stb),
        .o_prdata   (o_prdata)
    );

    assign global_interrupt_flag      = ctrl_reg[SMX_CTRL_GIF];
    assign intc     = ctrl_reg[SMX_CTRL_INTC];
    assign swap     = ctrl_reg[SMX_CTRL_SWAP];
    assign in_guest = ctrl_reg[SMX_CTRL_GUEST];

    // Internal traps versus external chipset sources
    assign int_irq = i_irq.valid && i_irq.src == SMX_SRC_INT_SYNC;
    // A new external request arriving in this cycle
    assign new_ext = i_irq.valid && i_irq.src != SMX_SRC_INT_SYNC;
    assign ext_irq = new_ext || ext_pend_reg;

    // Priority: already in mode blocks all; exit beats entry
    always_comb
    begin
        take_int = 1'b0;
        take_ext = 1'b0;
        exit_now = 1'b0;
        if (!in_mode_reg && global_interrupt_flag)
        begin
            if (in_guest && intc && (int_irq || ext_irq))
                exit_now = 1'b1;
            else if (int_irq)
                take_int = 1'b1;
            else if (ext_irq)
                take_ext = 1'b1;
        end
    end

    assign do_exit  = exit_now;
    assign do_entry = i_guest_entry && !in_guest && !in_mode_reg;

    // External pending; a request taken in its own cycle is not kept,
    // or it would be taken a second time after the resume
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            ext_pend_reg <= 1'b0;
        else if (new_ext && !take_ext)
            ext_pend_reg <= 1'b1;
        else if (take_ext)
            ext_pend_reg <= 1'b0;
    end

    // Internal interrupts with flag low simply vanish: no state kept

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            in_mode_reg         <= 1'b0;
            mode_from_guest_reg <= 1'b0;
        end
        else if (take_int || take_ext)
        begin
            in_mode_reg         <= 1'b1;
            mode_from_guest_reg <= in_guest;
        end
        else if (i_resume && in_mode_reg)
            in_mode_reg <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            exit_reg  <= 1'b0;
            enter_reg <= 1'b0;
        end
        else
        begin
            exit_reg  <= exit_now;
            enter_reg <= take_int | take_ext;
        end
    end

    assign locked_wr = wr_stb && i_paddr == SMX_MCTL_OFF
                       && ctrl_reg[SMX_CTRL_LOCK];

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            fault_reg <= 1'b0;
        else
            fault_reg <= locked_wr;
    end

    // Sticky copy of the fault for software; a status read clears it,
    // a fault in the same cycle as that read wins
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            fault_seen_reg <= 1'b0;
        else if (locked_wr)
            fault_seen_reg <= 1'b1;
        else if (rd_stb && i_paddr == SMX_STAT_OFF)
            fault_seen_reg <= 1'b0;
    end

    // Control: hardware updates of flag and guest bit win over software
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            ctrl_reg <= SMX_CTRL_RST;
        else
        begin
            if (wr_stb && i_paddr == SMX_CTRL_OFF)
            begin
                ctrl_reg[4:0] <= i_pwdata[4:0];
                // Lock is sticky until reset, as firmware intends
                ctrl_reg[SMX_CTRL_LOCK] <= ctrl_reg[SMX_CTRL_LOCK]
                                           | i_pwdata[SMX_CTRL_LOCK];
            end
            if (i_set_gif)
                ctrl_reg[SMX_CTRL_GIF] <= 1'b1;
            else if (i_clr_gif || exit_now)
                ctrl_reg[SMX_CTRL_GIF] <= 1'b0;
            if (exit_now)
                ctrl_reg[SMX_CTRL_GUEST] <= 1'b0;
            else if (do_entry)
                ctrl_reg[SMX_CTRL_GUEST] <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            mctl_reg  <= 32'h0000_0000;
            mbase_reg <= SMX_MBASE_RST;
        end
        else if (wr_stb && !ctrl_reg[SMX_CTRL_LOCK])
        begin
            if (i_paddr == SMX_MCTL_OFF)
                mctl_reg <= i_pwdata;
            if (i_paddr == SMX_MBASE_OFF)
                mbase_reg <= i_pwdata;
        end
    end

    // Extended debug control: host copy and guest copy both kept
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            edbg_reg       <= 32'h0000_0000;
            edbg_host_reg  <= 32'h0000_0000;
            edbg_guest_reg <= 32'h0000_0000;
        end
        else if (do_entry && swap)
        begin
            edbg_host_reg <= edbg_reg;
            edbg_reg      <= edbg_guest_reg;
        end
        else if (do_exit && swap)
        begin
            edbg_guest_reg <= edbg_reg;
            edbg_reg       <= edbg_host_reg;
        end
        else if (wr_stb && i_paddr == SMX_EDBG_OFF)
            edbg_reg <= i_pwdata;
    end

    // Stack registers have no host copy
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            stk_reg       <= 32'h0000_0000;
            stk_guest_reg <= 32'h0000_0000;
        end
        else if (do_entry && swap)
            stk_reg <= stk_guest_reg;
        else if (do_exit && swap)
        begin
            stk_guest_reg <= stk_reg;
            if (ctrl_reg[SMX_CTRL_ENC])
                stk_reg <= 32'h0000_0000;
        end
        else if (wr_stb && i_paddr == SMX_STK_OFF)
            stk_reg <= i_pwdata;
    end

    // Record capture: index 0 is debug control, 1..4 the four records
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            rec_ptr_reg <= 2'd0;
        else if (i_branch_taken && rec_en && !i_debug_exc)
            rec_ptr_reg <= rec_ptr_reg + 2'd1;
    end

    always_comb
    begin
        rec_wr    = 1'b0;
        rec_widx  = 3'd0;
        rec_wdata = 32'h0000_0000;
        if (wr_stb && i_paddr == SMX_REC_OFF)
        begin
            rec_wr    = 1'b1;
            rec_wdata = i_pwdata;
        end
        else if (i_branch_taken && !i_debug_exc)
        begin
            // Alternate source and target of the last transfer
            rec_wr    = 1'b1;
            rec_widx  = {1'b0, rec_ptr_reg} + 3'd1;
            rec_wdata = rec_ptr_reg[0] ? i_branch_dst : i_branch_src;
        end
    end

    // Capture gated by the live enable bit; the control word stays writable
    smx_rec_bank u_rec (
        .i_core_clk(i_core_clk),
        .i_reset   (i_reset),
        .i_wr      (rec_wr && (rec_widx == 3'd0 || rec_en)),
        .i_widx    (rec_widx),
        .i_wdata   (rec_wdata),
        .i_entry   (do_entry && swap),
        .i_exit    (do_exit && swap),
        .i_ridx    (i_paddr[4:2]),
        .o_live    (rec_live),
        .o_guest   (),
        .o_host    (),
        .o_rec_en  (rec_en)
    );

    // Status: 5 pending, 4 in mode, 3 from guest, 2 fault seen, 1 swap
    assign stat_word = {26'h0, ext_pend_reg, in_mode_reg,
                        mode_from_guest_reg, fault_seen_reg,
                        o_swap_supported, 1'b0};

    always_comb
    begin
        rdata = 32'h0000_0000;
        case (i_paddr)
            SMX_CTRL_OFF:  rdata = ctrl_reg;
            SMX_STAT_OFF:  rdata = stat_word;
            SMX_MCTL_OFF:  rdata = mctl_reg;
            SMX_MBASE_OFF: rdata = mbase_reg;
            SMX_EDBG_OFF:  rdata = edbg_reg;
            SMX_STK_OFF:   rdata = stk_reg;
            default:
            begin
                if (i_paddr >= SMX_REC_OFF)
                    rdata = rec_live;
            end
        endcase
    end

    assign o_pslverr = 1'b0;
    // One driver for the whole event word; only one exit kind exists here
    assign o_evt = '{exit_req:   exit_reg,
                     exit_code:  SMX_EXIT_SMI,
                     enter_mode: enter_reg,
                     fault:      fault_reg};
    assign o_in_mgmt_mode   = in_mode_reg;
    assign o_priv_mem_map   = in_mode_reg;
    assign o_swap_supported = SMX_SWAP_SUPPORTED;
endmodule
`default_nettype wire

// >>> verif/smx_guest_switch_chk.sv
// Port-level assertion checker for the guest-switch block
`timescale 1ns/1ps
`default_nettype none
module smx_guest_switch_chk
    import smx_pkg::*;
(
    input wire logic              i_core_clk,
    input wire logic              i_reset,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [SMX_AW-1:0] i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    input wire smx_irq_t          i_irq,
    input wire logic              i_set_gif,
    input wire logic              i_guest_entry,
    input wire logic              i_resume,
    input wire smx_evt_t          o_evt,
    input wire logic              o_in_mgmt_mode,
    input wire logic              o_priv_mem_map,
    input wire logic              o_swap_supported
);
    logic wr;
    logic lk_wr;
    logic cause;
    logic lock_reg;
    assign wr = i_psel && i_penable && i_pwrite;
    assign lk_wr = lock_reg && wr && i_paddr == SMX_MCTL_OFF;
    assign cause = i_irq.valid || i_set_gif || i_guest_entry || i_resume || wr;
    // Lock only ever sets, so the mirror needs no clear path
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            lock_reg <= 1'b0;
        else if (wr && i_paddr == SMX_CTRL_OFF && i_pwdata[SMX_CTRL_LOCK])
            lock_reg <= 1'b1;
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_lock_ctl_wr;
        lk_wr;
    endsequence
    sequence s_mode_stay;
        o_in_mgmt_mode && !i_resume;
    endsequence
    AST_SWAP_SUP: assert property (o_swap_supported)
        else $error("swap support low");
    AST_MAP_MODE: assert property (o_priv_mem_map == o_in_mgmt_mode)
        else $error("private map differs from mode");
    AST_EXIT_CODE: assert property (o_evt.exit_req |->
        o_evt.exit_code == SMX_EXIT_SMI) else $error("bad exit code");
    AST_EXIT_ONE: assert property (o_evt.exit_req |=> !o_evt.exit_req)
        else $error("exit longer than a pulse");
    AST_EXIT_CAUSE: assert property (o_evt.exit_req |-> $past(cause))
        else $error("exit without cause");
    AST_NOT_BOTH: assert property (o_evt.exit_req |-> !o_evt.enter_mode)
        else $error("exit and entry together");
    AST_MODE_HOLD: assert property (s_mode_stay |=> o_in_mgmt_mode)
        else $error("mode dropped without resume");
    AST_MODE_LEAVE: assert property (o_in_mgmt_mode && i_resume
        |=> !o_in_mgmt_mode) else $error("resume ignored");
    AST_FAULT_ON: assert property (s_lock_ctl_wr |=> o_evt.fault)
        else $error("locked write without fault");
    AST_FAULT_ONLY: assert property (o_evt.fault |-> $past(lk_wr))
        else $error("fault without locked write");
    AST_APB_ZW: assert property (i_psel && i_penable |->
        o_pready && !o_pslverr) else $error("bus answer wrong");
endmodule
bind smx_guest_switch smx_guest_switch_chk smx_guest_switch_chk_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_irq(i_irq), .i_set_gif(i_set_gif), .i_guest_entry(i_guest_entry),
    .i_resume(i_resume), .o_evt(o_evt), .o_in_mgmt_mode(o_in_mgmt_mode),
    .o_priv_mem_map(o_priv_mem_map), .o_swap_supported(o_swap_supported)
);
`default_nettype wire

// >>> verif/smx_agent.sv
// Chipset agent model that raises management interrupts
`timescale 1ns/1ps
`default_nettype none
module smx_agent
    import smx_pkg::*;
(
    input  wire logic     i_core_clk,
    input  wire smx_evt_t i_evt,
    output var smx_irq_t  o_irq
);
    initial o_irq = '{valid: 1'b0, src: SMX_SRC_EXT_ASYNC};
    // One-cycle request; the idle source field is scrambled on purpose
    task automatic raise(input smx_src_t s, output logic ex,
                         output logic en);
        o_irq <= '{valid: 1'b1, src: s};
        @(posedge i_core_clk);
        o_irq <= '{valid: 1'b0, src: smx_src_t'(~s)};
        #1;
        ex = i_evt.exit_req;
        en = i_evt.enter_mode;
        @(posedge i_core_clk);
    endtask
endmodule
`default_nettype wire

// >>> verif/smx_guest_switch_tb.sv
// Self-checking bench for the guest-switch block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("unexpected at %0t got %h exp %h", $time, g, e); \
        end \
    end
module smx_guest_switch_tb import smx_pkg::*;;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              psel = 1'b0;
    logic              pen = 1'b0;
    logic              pwr = 1'b0;
    logic [SMX_AW-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [4:0]        pls = '0;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    smx_irq_t          irq;
    smx_evt_t          evt;
    logic              mode;
    logic              pmap;
    logic              swsup;
    logic [31:0]       rd;
    logic              ex;
    logic              en;
    int                mismatches = 0;
    int                num_checks = 0;
    always #10 clk = ~clk;
    smx_guest_switch smx_guest_switch_i (
        .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_irq(irq), .i_set_gif(pls[0]), .i_clr_gif(pls[1]),
        .i_guest_entry(pls[2]), .i_resume(pls[3]), .i_branch_taken(pls[4]),
        .i_debug_exc(1'b0), .i_branch_src(32'h1111_1111),
        .i_branch_dst(32'h2222_2222),
        .o_evt(evt), .o_in_mgmt_mode(mode), .o_priv_mem_map(pmap),
        .o_swap_supported(swsup)
    );
    smx_agent smx_agent_i (.i_core_clk(clk), .i_evt(evt), .o_irq(irq));
    task automatic apb(input logic w, input logic [SMX_AW-1:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [SMX_AW-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdm(input logic [SMX_AW-1:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd & m, e)
    endtask
    task automatic pulse(input int b);
        pls[b] <= 1'b1;
        @(posedge clk);
        pls[b] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic irq_chk(input smx_src_t s, input logic xe, input logic ne);
        smx_agent_i.raise(s, ex, en);
        `CHK(ex, xe)
        `CHK(en, ne)
    endtask
    // Bounded wait; the pending take may lag the flag by a few cycles
    task automatic wait_mode();
        for (int i = 0; i < 8 && mode !== 1'b1; i++)
            @(posedge clk);
        `CHK(mode, 1'b1)
        `CHK(pmap, 1'b1)
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rdm(SMX_CTRL_OFF, 32'hFFFFFFFF, SMX_CTRL_RST);
        rdm(SMX_MBASE_OFF, 32'hFFFFFFFF, SMX_MBASE_RST);
        rdm(SMX_STAT_OFF, 32'h2, {SMX_SWAP_SUPPORTED, 1'b0});
        `CHK(swsup, SMX_SWAP_SUPPORTED)
        apb(1'b0, 6'h3C, 32'h0);
        `CHK(pslverr, 1'b0)
        irq_chk(SMX_SRC_INT_SYNC, 1'b0, 1'b0);
        rdm(SMX_STAT_OFF, 32'h20, 32'h0);
        irq_chk(SMX_SRC_EXT_ASYNC, 1'b0, 1'b0);
        rdm(SMX_STAT_OFF, 32'h30, 32'h20);
        pulse(0);
        wait_mode();
        rdm(SMX_STAT_OFF, 32'h30, 32'h10);
        pulse(3);
        `CHK(mode, 1'b0)
        wr(SMX_CTRL_OFF, 32'h2);
        pulse(0);
        pulse(2);
        irq_chk(SMX_SRC_INT_SYNC, 1'b1, 1'b0);
        rdm(SMX_STAT_OFF, 32'h20, 32'h0);
        rdm(SMX_CTRL_OFF, 32'h21, 32'h0);
        pulse(0);
        pulse(2);
        irq_chk(SMX_SRC_EXT_ASYNC, 1'b1, 1'b0);
        rdm(SMX_STAT_OFF, 32'h30, 32'h20);
        pulse(0);
        wait_mode();
        pulse(3);
        wr(SMX_CTRL_OFF, 32'h0);
        pulse(0);
        pulse(2);
        for (int s = 0; s < 3; s++)
        begin
            irq_chk(smx_src_t'(s), 1'b0, 1'b1);
            rdm(SMX_STAT_OFF, 32'h18, 32'h18);
            pulse(3);
            rdm(SMX_CTRL_OFF, 32'h20, 32'h20);
        end
        wr(SMX_CTRL_OFF, 32'hB);
        irq_chk(SMX_SRC_INT_SYNC, 1'b1, 1'b0);
        wr(SMX_REC_OFF, 32'h1);
        wr(SMX_EDBG_OFF, 32'hA5);
        pulse(0);
        pulse(2);
        rdm(SMX_REC_OFF, 32'hFFFFFFFF, 32'h0);
        rdm(SMX_EDBG_OFF, 32'hFFFFFFFF, 32'h0);
        wr(SMX_EDBG_OFF, 32'h3C);
        irq_chk(SMX_SRC_INT_SYNC, 1'b1, 1'b0);
        rdm(SMX_REC_OFF, 32'hFFFFFFFF, 32'h1);
        rdm(SMX_EDBG_OFF, 32'hFFFFFFFF, 32'hA5);
        pulse(4);
        pulse(4);
        rdm(6'h24, 32'hFFFFFFFF, 32'h1111_1111);
        rdm(6'h28, 32'hFFFFFFFF, 32'h2222_2222);
        wr(SMX_MCTL_OFF, 32'h5A);
        rdm(SMX_MCTL_OFF, 32'hFF, 32'h5A);
        wr(SMX_CTRL_OFF, 32'h4);
        wr(SMX_MCTL_OFF, 32'h3C);
        rdm(SMX_STAT_OFF, 32'h4, 32'h4);
        rdm(SMX_STAT_OFF, 32'h4, 32'h0);
        rdm(SMX_MCTL_OFF, 32'hFF, 32'h5A);
        wr(SMX_MBASE_OFF, 32'h10000);
        rdm(SMX_MBASE_OFF, 32'hFFFFFFFF, SMX_MBASE_RST);
        wr(SMX_CTRL_OFF, 32'h0);
        rdm(SMX_CTRL_OFF, 32'h4, 32'h4);
        end_sim();
    end
endmodule
`default_nettype wire
